// *** scp_pkg.sv ***
// constants and types shared by the serial command port
// assumes a single 25 MHz device clock
`default_nettype none
package scp_pkg;
	// --------------------------------------------------------------
	// clock, baud and delay timing
	// --------------------------------------------------------------
	localparam int CLK_HZ   = 25_000_000;
	localparam int BAUD_LO  = 300;
	localparam int BAUD_MID = 1200;
	localparam int BAUD_HI  = 9600;
	localparam int BIT_LO   = CLK_HZ / BAUD_LO;
	localparam int BIT_MID  = CLK_HZ / BAUD_MID;
	localparam int BIT_HI   = CLK_HZ / BAUD_HI;
	localparam int DLY_MS   = 10;
	localparam int DLY_CYC  = (CLK_HZ / 1000) * DLY_MS;
	localparam int CNT_W    = 17;
	localparam int DLY_W    = 18;
	typedef logic [CNT_W-1:0] cyc_t;
	typedef logic [DLY_W-1:0] dly_t;

	// --------------------------------------------------------------
	// framing and message layout
	// --------------------------------------------------------------
	localparam int         DATA_BITS  = 7;
	localparam logic [3:0] FRAME_BITS = 4'hA;
	localparam logic [3:0] STOP_IDX   = 4'h8;
	localparam int         MSG_MAX    = 64;
	localparam logic [1:0] SEL_LO     = 2'h0;
	localparam logic [1:0] SEL_MID    = 2'h1;

	// --------------------------------------------------------------
	// characters
	// --------------------------------------------------------------
	localparam logic [6:0] CH_CR   = 7'h0D;
	localparam logic [6:0] CH_LF   = 7'h0A;
	localparam logic [6:0] CH_SEMI = 7'h3B;
	localparam logic [6:0] CH_SP   = 7'h20;
	localparam logic [6:0] CH_QM   = 7'h3F;
	localparam logic [6:0] CH_PLUS = 7'h2B;

	// --------------------------------------------------------------
	// tail sequencing after a response
	// --------------------------------------------------------------
	localparam logic [1:0] TL_BODY = 2'h0;
	localparam logic [1:0] TL_DONE = 2'h1;
	localparam logic [1:0] TL_LF   = 2'h2;
	localparam logic [1:0] TL_CR   = 2'h3;
endpackage
`default_nettype wire

// *** scp_fifo2.sv ***
// two-entry valid/ready buffer
// assumes both sides on clk; full stalls the filling side
`default_nettype none
module scp_fifo2 #(
	parameter int W = 9
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              wp;
		logic              rp;
		logic [1:0]        cnt;
	} fst_t;

	fst_t q;
	fst_t n;
	logic push;
	logic pop;

	assign in_ready  = q.cnt != 2'h2;
	assign out_valid = q.cnt != 2'h0;
	assign out_data  = q.mem[q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		n = q;
		if (push) begin
			n.mem[q.wp] = in_data;
			n.wp        = ~q.wp;
		end
		if (pop)
			n.rp = ~q.rp;
		n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			q <= '0;
		else
			q <= n;
	end

	a_full_holds: assert property (@(posedge clk) disable iff (!arst_n)
		(q.cnt == 2'h2 && !out_ready) |=> (q.cnt == 2'h2 && !in_ready))
		else $error("buffer lost a word while full");
endmodule
`default_nettype wire

// *** scp_rx.sv ***
// serial character receiver: start, 7 data, parity, stop
// assumes rxd synchronous to clk, idle high
`default_nettype none
module scp_rx (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// line and setup
	input  wire logic             rxd,
	input  wire logic             en,
	input  wire scp_pkg::cyc_t    bit_cyc,
	// characters out
	output logic                  chr_valid,
	output logic            [6:0] chr_data,
	output logic                  chr_err,
	output logic                  busy
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rst_t;
	typedef struct packed {
		rst_t          st;
		logic          prev;
		scp_pkg::cyc_t cnt;
		logic [3:0]    idx;
		logic [7:0]    sh;
		logic          valid;
		logic          err;
		logic [6:0]    data;
	} rxs_t;

	rxs_t q;
	rxs_t n;

	assign chr_valid = q.valid;
	assign chr_data  = q.data;
	assign chr_err   = q.err;
	assign busy      = q.st != RX_IDLE;

	always_comb begin
		n       = q;
		n.valid = 1'b0;
		n.err   = 1'b0;
		n.prev  = rxd;
		unique case (q.st)
			RX_IDLE: begin
				if (en && q.prev && !rxd) begin // R23
					n.st  = RX_START;
					n.cnt = bit_cyc >> 1;
				end
			end
			RX_START: begin
				if (q.cnt == '0) begin
					// a short glitch is not a start bit
					n.st  = rxd ? RX_IDLE : RX_BITS;
					n.cnt = bit_cyc - 1'b1;
					n.idx = 4'h0;
				end else
					n.cnt = q.cnt - 1'b1;
			end
			RX_BITS: begin
				if (q.cnt == '0) begin
					n.cnt = bit_cyc - 1'b1; // R23
					if (q.idx == scp_pkg::STOP_IDX) begin
						n.st = RX_IDLE;
						if (rxd && ^q.sh) begin // R1 R2
							n.valid = 1'b1;
							n.data  = q.sh[6:0];
						end else
							n.err = 1'b1; // R24
					end else begin
						n.sh  = {rxd, q.sh[7:1]};
						n.idx = q.idx + 1'b1;
					end
				end else
					n.cnt = q.cnt - 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q      <= '0;
			q.prev <= 1'b1;
		end else
			q <= n;
	end

	a_mid_start: assert property (@(posedge clk) disable iff (!arst_n)
		(q.st == RX_START && q.cnt == '0 && !rxd) |=> (q.st == RX_BITS && q.idx == 4'h0)) // R23
		else $error("start bit not taken at its midpoint");
	a_bad_frame: assert property (@(posedge clk) disable iff (!arst_n)
		(q.st == RX_BITS && q.cnt == '0 && q.idx == scp_pkg::STOP_IDX && !rxd)
		|=> (chr_err && !chr_valid)) // R24
		else $error("framing error not flagged");
endmodule
`default_nettype wire

// *** scp_top.sv ***
// serial command port: frames, splits and answers host messages
// assumes one 25 MHz clock and an application that decodes elements
// What the document requires of the block and of the host
// R1: each character is start, seven data bits, parity, stop: ten bits
// R2: odd parity is sent on every character and checked on receive
// R3: bit rate selectable among 300, 1200 and 9600 baud only
// R4: half duplex: never transmits while a message is being received
// R5: no handshake lines exist; host software timing does flow control
// R6: CR then LF ends a message; every response ends with CR LF
// R7: host must append CR LF; without it the message never completes
// R8: semicolons split chained commands, each handed on in turn
// R9: host sends at most one query, placed last in the chain
// R10: host keeps a whole communication within 64 characters
// R11: command is mnemonic, space, parameters; applied on receipt
// R12: query is mnemonic with question mark; it obliges a response
// R13: only the most recent query is answered; older answers dropped
// R14: response starts about 10 ms after the query completes
// R15: unrecognised mnemonics are ignored silently with no response
// R16: a query mnemonic lacking its question mark gets no response
// R17: parameters may omit plus sign; responses are sent zero padded
// R18: a pure command sends nothing back
// R19: host sends at most twenty commands per second
// R20: host should leave 50 ms between successive commands
// R21: device never transmits except to answer a received query
// R22: host starts nothing for 50 ms after command or response
// R23: start detected on falling edge, bits sampled at midpoint
// R24: bad parity or stop drops and flags; overflow clears buffer
`default_nettype none
module scp_top #(
	parameter int BIT_LO  = scp_pkg::BIT_LO,
	parameter int BIT_MID = scp_pkg::BIT_MID,
	parameter int BIT_HI  = scp_pkg::BIT_HI,
	parameter int DLY_CYC = scp_pkg::DLY_CYC,
	parameter int MSG_MAX = scp_pkg::MSG_MAX
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// serial line
	input  wire logic       rxd,
	output logic            txd,
	// setup
	input  wire logic [1:0] baud_sel,
	// element stream to the application
	output logic            el_valid,
	input  wire logic       el_ready,
	output logic      [6:0] el_data,
	output logic            el_last,
	output logic            el_query,
	// response from the application
	input  wire logic       resp_valid,
	output logic            resp_ready,
	input  wire logic [6:0] resp_data,
	input  wire logic       resp_last,
	input  wire logic       resp_drop,
	// status pulses
	output logic            rx_err,
	output logic            ovf
);
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	localparam int LW = $clog2(MSG_MAX + 1);
	typedef enum logic [1:0] {PH_RX, PH_SCAN, PH_WAIT, PH_TX} ph_t;
	typedef struct packed {
		ph_t                      ph;
		logic [MSG_MAX-1:0][6:0]  mem;
		logic [LW-1:0]            len;
		logic                     cr;
		logic [LW-1:0]            rd;
		logic                     fresh;
		logic                     mn;
		logic                     pst;
		logic                     qel;
		logic                     qpend;
		scp_pkg::dly_t            dly;
		logic                     tx_busy;
		logic [9:0]               tx_sh;
		logic [3:0]               tx_n;
		scp_pkg::cyc_t            tx_cnt;
		logic [1:0]               tail;
		logic                     txd;
		logic                     rdy;
		logic                     err;
		logic                     ovf;
	} st_t;

	st_t           q;
	st_t           n;
	scp_pkg::cyc_t bit_cyc;
	logic          chr_valid;
	logic [6:0]    chr_data;
	logic          chr_err;
	logic          rx_busy;
	logic          push;
	logic          push_rdy;
	logic [8:0]    push_word;
	logic [8:0]    out_word;
	logic [LW-1:0] rd1;
	logic [6:0]    cur;
	logic [6:0]    nxt;
	logic          qel_now;
	logic          last_now;
	logic [6:0]    ld_chr;
	logic          ld;

	assign txd        = q.txd;
	assign resp_ready = q.rdy;
	assign rx_err     = q.err;
	assign ovf        = q.ovf;
	assign el_data    = out_word[6:0];
	assign el_query   = out_word[7];
	assign el_last    = out_word[8];

	// --------------------------------------------------------------
	// baud selection
	// --------------------------------------------------------------
	always_comb begin
		unique case (baud_sel) // R3
			scp_pkg::SEL_LO:  bit_cyc = scp_pkg::cyc_t'(BIT_LO);
			scp_pkg::SEL_MID: bit_cyc = scp_pkg::cyc_t'(BIT_MID);
			default:          bit_cyc = scp_pkg::cyc_t'(BIT_HI);
		endcase
	end

	// --------------------------------------------------------------
	// receiver and element buffer
	// --------------------------------------------------------------
	// receiver is off while sending, so own echo never lands in the buffer
	scp_rx u_rx (
		.clk       (clk),
		.arst_n    (arst_n),
		.rxd       (rxd),
		.en        (q.ph != PH_TX), // R4
		.bit_cyc   (bit_cyc),
		.chr_valid (chr_valid),
		.chr_data  (chr_data),
		.chr_err   (chr_err),
		.busy      (rx_busy)
	);

	scp_fifo2 #(.W(9)) u_buf (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (push),
		.in_ready  (push_rdy),
		.in_data   (push_word),
		.out_valid (el_valid),
		.out_ready (el_ready),
		.out_data  (out_word)
	);

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		n         = q;
		n.err     = chr_err; // R24
		n.ovf     = 1'b0;
		push      = 1'b0;
		ld        = 1'b0;
		ld_chr    = resp_data;
		rd1       = q.rd + 1'b1;
		cur       = q.mem[q.rd];
		nxt       = (rd1 < q.len) ? q.mem[rd1] : scp_pkg::CH_SEMI;
		qel_now   = q.qel || (q.mn && cur == scp_pkg::CH_QM); // R12 R16
		last_now  = nxt == scp_pkg::CH_SEMI;
		push_word = {last_now, qel_now, cur};

		// message capture; a new message cancels a pending answer
		if (chr_valid && (q.ph == PH_RX || q.ph == PH_WAIT)) begin
			if (q.ph == PH_WAIT) begin
				n.ph    = PH_RX; // R13
				n.qpend = 1'b0;
				n.len   = '0;
			end
			if (chr_data == scp_pkg::CH_CR)
				n.cr = 1'b1;
			else if (chr_data == scp_pkg::CH_LF && q.cr) begin
				n.ph    = PH_SCAN; // R6 R7
				n.cr    = 1'b0;
				n.rd    = '0;
				n.fresh = 1'b1;
				n.mn    = 1'b1;
				n.pst   = 1'b0;
				n.qel   = 1'b0;
				n.qpend = 1'b0;
			end else begin
				n.cr = 1'b0;
				if (n.len == LW'(MSG_MAX)) begin
					n.len = '0; // R24 R10
					n.ovf = 1'b1;
				end else begin
					n.mem[n.len] = chr_data;
					n.len        = n.len + 1'b1;
				end
			end
		end

		unique case (q.ph)
			PH_RX: ;
			PH_SCAN: begin
				if (q.rd == q.len) begin
					n.ph  = q.qpend ? PH_WAIT : PH_RX; // R18 R21
					n.dly = '0;
					n.len = '0;
				end else if (cur == scp_pkg::CH_SEMI) begin
					n.rd    = rd1; // R8
					n.fresh = 1'b1;
					n.mn    = 1'b1;
					n.pst   = 1'b0;
					n.qel   = 1'b0;
				end else if (cur == scp_pkg::CH_SP && q.fresh)
					n.rd = rd1;
				else if (cur == scp_pkg::CH_PLUS && q.pst) begin
					n.rd  = rd1; // R17
					n.pst = 1'b0;
				end else if (push_rdy) begin
					// buffer full stalls the scan, nothing is lost
					push    = 1'b1; // R11
					n.rd    = rd1;
					n.fresh = 1'b0;
					n.pst   = cur == scp_pkg::CH_SP && q.mn;
					n.mn    = q.mn && cur != scp_pkg::CH_SP;
					n.qel   = qel_now;
					if (last_now)
						n.qpend = q.qpend || qel_now; // R13
				end
			end
			PH_WAIT: begin
				// a character still arriving holds the answer back
				if (n.ph == PH_WAIT && !rx_busy) begin // R4
					if (q.dly == scp_pkg::dly_t'(DLY_CYC - 1)) begin
						n.ph   = PH_TX; // R14
						n.tail = scp_pkg::TL_BODY;
					end else
						n.dly = q.dly + 1'b1;
				end
			end
			PH_TX: begin
				if (!q.tx_busy) begin
					if (q.tail == scp_pkg::TL_BODY) begin
						if (resp_drop) begin
							n.ph    = PH_RX; // R15
							n.qpend = 1'b0;
						end else if (q.rdy && resp_valid) begin
							ld = 1'b1;
							if (resp_last)
								n.tail = scp_pkg::TL_CR;
						end
					end else if (q.tail == scp_pkg::TL_CR) begin
						ld     = 1'b1; // R6
						ld_chr = scp_pkg::CH_CR;
						n.tail = scp_pkg::TL_LF;
					end else if (q.tail == scp_pkg::TL_LF) begin
						ld     = 1'b1;
						ld_chr = scp_pkg::CH_LF;
						n.tail = scp_pkg::TL_DONE;
					end else begin
						n.ph    = PH_RX;
						n.qpend = 1'b0;
					end
				end
			end
		endcase

		// transmitter: start bit first, data lsb first, parity, stop
		if (ld) begin
			n.tx_sh   = {1'b1, ~^ld_chr, ld_chr, 1'b0}; // R1 R2
			n.tx_n    = scp_pkg::FRAME_BITS;
			n.tx_cnt  = bit_cyc - 1'b1;
			n.tx_busy = 1'b1;
			n.txd     = 1'b0;
		end else if (q.tx_busy) begin
			if (q.tx_cnt == '0) begin
				n.tx_cnt = bit_cyc - 1'b1;
				if (q.tx_n == 4'h1)
					n.tx_busy = 1'b0;
				else begin
					n.tx_sh = {1'b1, q.tx_sh[9:1]};
					n.txd   = n.tx_sh[0];
					n.tx_n  = q.tx_n - 1'b1;
				end
			end else
				n.tx_cnt = q.tx_cnt - 1'b1;
		end
		// no handshake: ready only reflects own transmitter state
		n.rdy = n.ph == PH_TX && !n.tx_busy && n.tail == scp_pkg::TL_BODY && !ld; // R5
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q     <= '0;
			q.txd <= 1'b1;
		end else
			q <= n;
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_tx_begin;
		!q.tx_busy ##1 q.tx_busy;
	endsequence
	sequence s_msg_end;
		chr_valid && chr_data == scp_pkg::CH_LF && q.cr && q.ph == PH_RX;
	endsequence

	a_line_quiet: assert property ((q.ph != PH_TX && !q.tx_busy) |-> q.txd) // R21
		else $error("line driven outside a response");
	a_half_duplex: assert property (rx_busy |-> (q.txd && !q.tx_busy)) // R4
		else $error("transmitting while receiving");
	a_start_bit: assert property (s_tx_begin |-> (!q.txd && q.tx_n == 4'hA)) // R1
		else $error("frame does not open with start bit");
	a_odd_parity: assert property ($rose(q.tx_busy) |-> (^q.tx_sh[8:1] == 1'b1)) // R2
		else $error("parity is not odd");
	a_term_ends: assert property (s_msg_end |=> (q.ph == PH_SCAN && q.rd == '0)) // R6
		else $error("terminator did not end the message");
	a_cmd_silent: assert property ((q.ph == PH_SCAN && q.rd == q.len && !q.qpend) |=> q.ph == PH_RX) // R18
		else $error("pure command led to a response");
	a_delay_kept: assert property ((q.ph == PH_WAIT && n.ph == PH_TX)
		|-> q.dly == scp_pkg::dly_t'(DLY_CYC - 1)) // R14
		else $error("response started before its delay");
	a_new_drops: assert property ((q.ph == PH_WAIT && chr_valid) |=> (q.ph == PH_RX && !q.qpend)) // R13
		else $error("older answer not discarded");
endmodule
`default_nettype wire

// *** scp_host.sv ***
// host program model: sends framed strings, decodes replies on txd
// assumes the bench sets bit_cyc to match the block's baud select
`default_nettype none
module scp_host (
	// clock
	input  wire logic        clk,
	// serial line
	output logic             rxd,
	input  wire logic        txd,
	// setup
	input  wire logic [15:0] bit_cyc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] rx_q[$];
	int         n_perr;
	logic       sending;
	initial begin
		rxd = 1'b1;
		sending = 1'b0;
		n_perr = 0;
	end
	// --------------------------------------------------------------
	// sending
	// --------------------------------------------------------------
	// bad[0] flips parity, bad[1] pulls the stop bit low; both on purpose
	task automatic send_char(input logic [6:0] c, input logic [1:0] bad);
		logic [9:0] f;
		f = {~bad[1], ~^c ^ bad[0], c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bit_cyc) @(negedge clk);
		end
		// a low stop leaves the line low: one idle bit so the next start has an edge
		if (bad[1]) begin
			rxd <= 1'b1;
			repeat (bit_cyc) @(negedge clk);
		end
	endtask
	// whole string in one go; term off only to test overflow
	task automatic send_str(input string s, input logic term);
		byte b;
		sending = 1'b1;
		foreach (s[i]) begin
			b = s[i];
			send_char(b[6:0], 2'h0);
		end
		if (term) begin
			send_char(7'h0D, 2'h0);
			send_char(7'h0A, 2'h0);
		end
		sending = 1'b0;
		repeat (20) @(negedge clk);
	endtask
	// --------------------------------------------------------------
	// receiving
	// --------------------------------------------------------------
	// midpoint sampling so a late start edge still decodes
	initial forever begin
		logic [9:0] f;
		@(negedge txd);
		repeat (bit_cyc / 2) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			f[i] = txd;
			if (i < 9) repeat (bit_cyc) @(posedge clk);
		end
		if (f[0] !== 1'b0 || f[9] !== 1'b1 || ^f[8:1] !== 1'b1) n_perr++;
		rx_q.push_back(f[7:1]);
	end
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the serial command port
// assumes shortened bit and delay counts; host model on the line
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DLY = 20;
	logic        clk, arst_n, rxd, txd, el_valid, el_ready, el_last, el_query;
	logic        resp_valid, resp_ready, resp_last, resp_drop, rx_err, ovf, stall;
	logic [1:0]  baud_sel;
	logic [6:0]  el_data, resp_data;
	logic [15:0] bit_cyc;
	logic [8:0]  el_q[$];
	int          n_fail, compares, n_rxerr, n_ovf, quiet;

	scp_top #(.BIT_LO(16), .BIT_MID(8), .BIT_HI(4), .DLY_CYC(DLY), .MSG_MAX(64)) i_dut (
		.clk(clk), .arst_n(arst_n), .rxd(rxd), .txd(txd), .baud_sel(baud_sel),
		.el_valid(el_valid), .el_ready(el_ready), .el_data(el_data), .el_last(el_last),
		.el_query(el_query), .resp_valid(resp_valid), .resp_ready(resp_ready),
		.resp_data(resp_data), .resp_last(resp_last), .resp_drop(resp_drop),
		.rx_err(rx_err), .ovf(ovf)
	);
	scp_host i_host (.clk(clk), .rxd(rxd), .txd(txd), .bit_cyc(bit_cyc));

	// --------------------------------------------------------------
	// clock, monitors, shared tasks
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (el_valid === 1'b1 && el_ready === 1'b1) el_q.push_back({el_query, el_last, el_data});
		if (rx_err === 1'b1) n_rxerr++;
		if (ovf === 1'b1) n_ovf++;
	end
	always @(negedge clk) begin
		el_ready <= !stall;
		// cycles since the host's last stop bit, frozen while a reply char is wanted
		quiet <= i_host.sending ? 0 : (resp_ready === 1'b1 ? quiet : quiet + 1);
		if (i_host.sending) check(16'(txd), 16'h0001, "txd while receiving");
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic do_reset;
		arst_n = 1'b0;
		repeat (20) @(negedge clk);
		check(16'({txd, el_valid, resp_ready, rx_err, ovf}), 16'h0010, "reset outputs");
		arst_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	task automatic set_baud(input logic [1:0] sel);
		baud_sel = sel;
		bit_cyc = (sel == 2'h0) ? 16'h0010 : (sel == 2'h1) ? 16'h0008 : 16'h0004;
	endtask
	// '|' closes an element; query means '?' ahead of the first space
	task automatic expect_elems(input string s);
		logic [8:0] e[$];
		logic       sp, q;
		byte        b;
		int         t;
		sp = 1'b0;
		q = 1'b0;
		t = 0;
		foreach (s[i]) begin
			b = s[i];
			if (b == "|") begin
				e[e.size()-1][8:7] = {q, 1'b1};
				sp = 1'b0;
				q = 1'b0;
			end else begin
				e.push_back({2'b00, b[6:0]});
				if (b == " ") sp = 1'b1;
				if (b == "?" && !sp) q = 1'b1;
			end
		end
		while (el_q.size() < e.size() && t < 3000) begin
			@(negedge clk);
			t++;
		end
		repeat (10) @(negedge clk);
		check(16'(el_q.size()), 16'(e.size()), "element count");
		foreach (e[i])
			if (i < el_q.size())
				check(16'(e[i][7] ? el_q[i] : el_q[i] & 9'h0FF), 16'(e[i]), "element char");
		el_q.delete();
	endtask
	task automatic answer(input string r);
		byte b;
		int  t;
		foreach (r[i]) begin
			t = 0;
			while (resp_ready !== 1'b1 && t < 3000) begin
				@(negedge clk);
				t++;
			end
			// scan time adds to the delay; the stop bit's tail takes a little off
			if (i == 0) check(16'(quiet > DLY - 10 && quiet < DLY + 80), 16'h0001, "reply delay");
			b = r[i];
			resp_valid = 1'b1;
			resp_data = b[6:0];
			resp_last = (i == r.len() - 1);
			@(negedge clk);
			resp_valid = 1'b0;
		end
	endtask
	task automatic expect_resp(input string r);
		string x;
		int    t;
		x = {r, "\x0D\x0A"};
		t = 0;
		while (i_host.rx_q.size() < x.len() && t < 6000) begin
			@(negedge clk);
			t++;
		end
		repeat (40 * bit_cyc) @(negedge clk);
		check(16'(i_host.rx_q.size()), 16'(x.len()), "reply length");
		foreach (x[i]) if (i < i_host.rx_q.size()) check(16'(i_host.rx_q[i]), 16'(x[i]), "reply char");
		check(16'(i_host.n_perr), 16'h0000, "reply framing");
		i_host.rx_q.delete();
	endtask
	task automatic silence;
		repeat (DLY + 300) @(negedge clk);
		check(16'(i_host.rx_q.size()), 16'h0000, "no reply");
		check(16'(resp_ready), 16'h0000, "no reply wanted");
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_chain;
		i_host.send_str("RANGE 1; RANGE?", 1'b1);
		expect_elems("RANGE 1|RANGE?|");
		answer("1");
		expect_resp("1");
	endtask
	task automatic t_bauds;
		for (int s = 0; s < 3; s++) begin
			set_baud(2'(s));
			i_host.send_str("KRDG?", 1'b1);
			expect_elems("KRDG?|");
			answer("+273.15");
			expect_resp("+273.15");
		end
	endtask
	task automatic t_pure;
		i_host.send_str("SETP +5;RANGE", 1'b1);
		expect_elems("SETP 5|RANGE|");
		silence;
	endtask
	task automatic t_multi;
		i_host.send_str("A?;B?", 1'b1);
		expect_elems("A?|B?|");
		answer("7");
		expect_resp("7");
	endtask
	task automatic t_unknown;
		i_host.send_str("XYZ?", 1'b1);
		expect_elems("XYZ?|");
		resp_drop = 1'b1;
		repeat (DLY + 10) @(negedge clk);
		resp_drop = 1'b0;
		silence;
	endtask
	task automatic t_parity;
		n_rxerr = 0;
		i_host.send_char(7'h51, 2'h1);
		i_host.send_char(7'h52, 2'h2);
		i_host.send_str("K", 1'b1);
		expect_elems("K|");
		check(16'(n_rxerr), 16'h0002, "parity and stop flags");
	endtask
	task automatic t_stall;
		stall = 1'b1;
		i_host.send_str("AB;CD", 1'b1);
		repeat (10) @(negedge clk);
		check(16'(el_valid), 16'h0001, "held element");
		stall = 1'b0;
		expect_elems("AB|CD|");
	endtask
	task automatic t_ovf;
		string s;
		s = "";
		n_ovf = 0;
		for (int i = 0; i < 65; i++) s = {s, "A"};
		i_host.send_str(s, 1'b0);
		repeat (20) @(negedge clk);
		check(16'(n_ovf), 16'h0001, "overflow flag");
		do_reset;
	endtask

	// --------------------------------------------------------------
	// main sequence and watchdog
	// --------------------------------------------------------------
	initial begin
		n_fail = 0;
		compares = 0;
		stall = 1'b0;
		resp_valid = 1'b0;
		resp_data = 7'h00;
		resp_last = 1'b0;
		resp_drop = 1'b0;
		set_baud(2'h2);
		do_reset;
		t_chain;
		t_bauds;
		t_pure;
		t_multi;
		t_unknown;
		t_parity;
		t_stall;
		t_ovf;
		complete_run;
	end
	// generous: the sequence needs about an eighth of this
	initial begin
		#4_000_000;
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run;
	end
endmodule
`default_nettype wire
